/* tsa_pkg.sv */
package tsa_pkg;
  // array geometry
  localparam int ADDR_W  = 15;                 // entry index width
  localparam int DATA_W  = 68;                 // one cell row
  localparam int LEN_W   = 9;                  // burst length width
  localparam int PAGE_W  = 13;                 // four-entry page index
  localparam int KEY_W   = 272;                // widest search key
  localparam int REG_AW  = 7;                  // register address width

  // register offsets
  localparam logic [REG_AW-1:0] REG_NEXT_FREE = 7'h60;
  localparam logic [REG_AW-1:0] REG_RBURST    = 7'h61;
  localparam logic [REG_AW-1:0] REG_WBURST    = 7'h62;
  localparam logic [REG_AW-1:0] REG_CONFIG    = 7'h63;
  localparam logic [REG_AW-1:0] REG_STATUS    = 7'h64;

  // burst pointer layout
  localparam int PTR_ADDR_LSB = 0;
  localparam int PTR_LEN_LSB  = 19;
  // config layout: width codes in 7:0, then the two cascade flags
  localparam int CFG_WIDTH_LSB = 0;
  localparam int CFG_LAST_CASC = 8;
  localparam int CFG_LAST_MEM  = 9;
  // status layout
  localparam int STA_BUSY_BIT = 0;
  localparam int STA_FULL_LSB = 1;

  // reset values
  localparam logic [ADDR_W-1:0] PTR_ADDR_RESET = 15'h0000;
  localparam logic [LEN_W-1:0]  PTR_LEN_RESET  = 9'h000;
  localparam logic [7:0]        CFG_RESET      = 8'h00;
  localparam logic [ADDR_W-1:0] NF_RESET       = 15'h0000;

  // command codes
  localparam logic [1:0] CMD_READ   = 2'h0;
  localparam logic [1:0] CMD_WRITE  = 2'h1;
  localparam logic [1:0] CMD_SEARCH = 2'h2;
  localparam logic [1:0] CMD_LEARN  = 2'h3;

  // quadrant width codes
  localparam logic [1:0] W68  = 2'h0;
  localparam logic [1:0] W136 = 2'h1;
  localparam logic [1:0] W272 = 2'h2;

  // output values
  localparam logic [1:0]        FULL_ON   = 2'h3;
  localparam logic [ADDR_W-1:0] IDLE_ADDR = 15'h7fff;
  localparam logic [PAGE_W-1:0] LAST_PAGE = 13'h1fff;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SEARCH,
    ST_FREE,
    ST_ARB
  } state_type;
endpackage : tsa_pkg

/* ternary_search_array_core.sv */
// The implementer's own choice: strobed register access.
`timescale 1ns/100ps
// Function
// - read pointer address increments per burst read
// - write pointer address increments per burst write
// - read burst length decrements per access
// - write burst length decrements per access
// - pointers reset to zero, reserved bits
// - entry bit zero marks occupancy
// - write or learn updates next free index
// - next free index at address 60
// - all occupied drives full output to ones
// - next free index even in 136 quadrants
// - 32K data cells each with mask
// - each quadrant searched at own width
// - per bit match under global, local mask
// - entry hits only when all bits match
// - wide entries need aligned group match
// - cascade picks at most one global winner
// - on a hit only the global winner drives result outputs
// - last devices drive outputs on no hit
// - last device drives miss and idle values
// - two bit width code per quadrant
module ternary_search_array_core
  import tsa_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              nrst,
  // register port
  input  wire logic [REG_AW-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  // command port
  input  wire logic              cmd_valid,
  input  wire logic [1:0]        cmd_code,
  input  wire logic              cmd_burst,
  input  wire logic              cmd_mask,
  input  wire logic [ADDR_W-1:0] cmd_addr,
  input  wire logic [DATA_W-1:0] cmd_wdata,
  input  wire logic [KEY_W-1:0]  cmd_key,
  input  wire logic [KEY_W-1:0]  cmd_gmask,
  output logic                   cmd_ready,
  output logic      [DATA_W-1:0] cmd_rdata,
  output logic                   cmd_rvalid,
  // cascade
  input  wire logic              cascade_prior_hit,
  input  wire logic              cascade_any_hit,
  output logic                   local_hit_out,
  // result pins with enables
  output logic      [ADDR_W-1:0] memory_address_bus,
  output logic                   memory_address_oe,
  output logic                   search_hit_flag,
  output logic                   search_hit_flag_oe,
  output logic                   search_result_valid,
  output logic                   search_result_valid_oe,
  output logic      [1:0]        array_full_out
);

  // all control state in one record
  typedef struct packed {
    state_type         state;
    logic [PAGE_W-1:0] page;       // scan position
    logic [ADDR_W-1:0] rptr_addr;
    logic [LEN_W-1:0]  rptr_len;
    logic [ADDR_W-1:0] wptr_addr;
    logic [LEN_W-1:0]  wptr_len;
    logic [7:0]        width_cfg;
    logic              last_in_cascade_bit;
    logic              last_on_memory_bus_bit;
    logic [ADDR_W-1:0] next_free_index;
    logic [1:0]        full;
    logic              found;      // local winner seen
    logic [ADDR_W-1:0] hit_addr;
    logic [KEY_W-1:0]  key;
    logic [KEY_W-1:0]  gmask;
    logic [DATA_W-1:0] rdata;
    logic [DATA_W-1:0] crdata;
    logic              crvalid;
    logic              ready;
    logic              local_hit;
    logic [ADDR_W-1:0] addr_out;
    logic              addr_oe;
    logic              flag;
    logic              flag_oe;
    logic              valid;
    logic              valid_oe;
  } state_rec_type;

  state_rec_type s_r;             // registered state
  state_rec_type s_nxt;           // next state

  // reset release through two flops
  logic rst_meta_r;
  logic rst_sync_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // cell storage, no reset: contents are undefined until written
  logic [DATA_W-1:0] data_mem [2**ADDR_W];
  logic [DATA_W-1:0] mask_mem [2**ADDR_W];

  // write ports driven from the comb process
  logic              we0;         // single or burst write
  logic              we0_mask;    // selects mask array
  logic [ADDR_W-1:0] wa0;
  logic [DATA_W-1:0] wd0;
  logic              we1;         // learn, first entry
  logic              we2;         // learn, partner entry
  logic [ADDR_W-1:0] wa1;
  logic [DATA_W-1:0] wd1;
  logic [DATA_W-1:0] wd2;

  // storage writes
  always_ff @(posedge clk) begin
    if (we0) begin
      if (we0_mask) begin
        mask_mem[wa0] <= wd0;
      end else begin
        data_mem[wa0] <= wd0;
      end
    end
    if (we1) begin
      data_mem[wa1] <= wd1;
    end
    if (we2) begin
      data_mem[wa1 | 15'h0001] <= wd2;
    end
  end

  // current page quadrant width
  logic [1:0] q_width;
  assign q_width = s_r.width_cfg[2*s_r.page[PAGE_W-1:PAGE_W-2] +: 2];

  logic [3:0] ent_match;          // per entry full match
  logic [3:0] ent_empty;          // per entry occupancy clear

  // four entries of the page compared in parallel
  for (genvar k = 0; k < 4; k++) begin : g_ent
    logic [DATA_W-1:0] d;
    logic [DATA_W-1:0] m;
    logic [DATA_W-1:0] key_s;
    logic [DATA_W-1:0] gm_s;
    assign d = data_mem[{s_r.page, 2'(k)}];
    assign m = mask_mem[{s_r.page, 2'(k)}];
    // each width picks its own key slice
    always_comb begin
      unique case (q_width)
        W136: begin
          key_s = s_r.key[(k%2)*DATA_W +: DATA_W];
          gm_s  = s_r.gmask[(k%2)*DATA_W +: DATA_W];
        end
        W272: begin
          key_s = s_r.key[k*DATA_W +: DATA_W];
          gm_s  = s_r.gmask[k*DATA_W +: DATA_W];
        end
        default: begin
          key_s = s_r.key[DATA_W-1:0];
          gm_s  = s_r.gmask[DATA_W-1:0];
        end
      endcase
    end
    // masked bit forced true, else stored equals search
    assign ent_match[k] = &(~gm_s | ~m | ~(d ^ key_s));
    assign ent_empty[k] = ~d[0];
  end

  // page hit and lowest offset for the quadrant width
  logic       pg_hit;
  logic [1:0] pg_off;
  logic       pg_free;
  logic [1:0] pg_free_off;

  always_comb begin
    pg_hit      = 1'b0;
    pg_off      = 2'h0;
    pg_free     = 1'b0;
    pg_free_off = 2'h0;
    unique case (q_width)
      W68: begin
        pg_hit = |ent_match;
        // lowest entry first
        if (ent_match[0]) begin
          pg_off = 2'h0;
        end else if (ent_match[1]) begin
          pg_off = 2'h1;
        end else if (ent_match[2]) begin
          pg_off = 2'h2;
        end else begin
          pg_off = 2'h3;
        end
        pg_free = |ent_empty;
        if (ent_empty[0]) begin
          pg_free_off = 2'h0;
        end else if (ent_empty[1]) begin
          pg_free_off = 2'h1;
        end else if (ent_empty[2]) begin
          pg_free_off = 2'h2;
        end else begin
          pg_free_off = 2'h3;
        end
      end
      W136: begin
        // even/odd pairs, both halves must match
        pg_hit = (&ent_match[1:0]) | (&ent_match[3:2]);
        pg_off = (&ent_match[1:0]) ? 2'h0 : 2'h2;
        // only even entries are candidates
        pg_free     = ent_empty[0] | ent_empty[2];
        pg_free_off = ent_empty[0] ? 2'h0 : 2'h2;
      end
      W272: begin
        pg_hit  = &ent_match;
        pg_free = ent_empty[0];
      end
      default: begin
        // reserved width code: quadrant never hits nor frees
        pg_hit  = 1'b0;
      end
    endcase
  end

  // next state
  always_comb begin
    s_nxt    = s_r;
    we0      = 1'b0;
    we0_mask = cmd_mask;
    wa0      = cmd_addr;
    wd0      = cmd_wdata;
    we1      = 1'b0;
    we2      = 1'b0;
    wa1      = s_r.next_free_index;
    wd1      = s_r.key[DATA_W-1:0] | 68'h1;
    wd2      = s_r.key[2*DATA_W-1:DATA_W] | 68'h1;
    s_nxt.crvalid = 1'b0;

    // register reads answer one cycle later
    s_nxt.rdata = '0;
    if (reg_rd) begin
      unique case (reg_addr)
        REG_NEXT_FREE: begin
          s_nxt.rdata[ADDR_W-1:0] = s_r.next_free_index;
        end
        REG_RBURST: begin
          s_nxt.rdata[PTR_ADDR_LSB +: ADDR_W] = s_r.rptr_addr;
          s_nxt.rdata[PTR_LEN_LSB +: LEN_W]   = s_r.rptr_len;
        end
        REG_WBURST: begin
          s_nxt.rdata[PTR_ADDR_LSB +: ADDR_W] = s_r.wptr_addr;
          s_nxt.rdata[PTR_LEN_LSB +: LEN_W]   = s_r.wptr_len;
        end
        REG_CONFIG: begin
          s_nxt.rdata[CFG_WIDTH_LSB +: 8]  = s_r.width_cfg;
          s_nxt.rdata[CFG_LAST_CASC]       = s_r.last_in_cascade_bit;
          s_nxt.rdata[CFG_LAST_MEM]        = s_r.last_on_memory_bus_bit;
        end
        REG_STATUS: begin
          s_nxt.rdata[STA_BUSY_BIT]      = s_r.state != ST_IDLE;
          s_nxt.rdata[STA_FULL_LSB +: 2] = s_r.full;
        end
        default: begin
          s_nxt.rdata = '0;
        end
      endcase
    end

    // register writes, reserved bits dropped
    if (reg_wr) begin
      unique case (reg_addr)
        REG_RBURST: begin
          s_nxt.rptr_addr = reg_wdata[PTR_ADDR_LSB +: ADDR_W];
          s_nxt.rptr_len  = reg_wdata[PTR_LEN_LSB +: LEN_W];
        end
        REG_WBURST: begin
          s_nxt.wptr_addr = reg_wdata[PTR_ADDR_LSB +: ADDR_W];
          s_nxt.wptr_len  = reg_wdata[PTR_LEN_LSB +: LEN_W];
        end
        REG_CONFIG: begin
          s_nxt.width_cfg = reg_wdata[CFG_WIDTH_LSB +: 8];
          s_nxt.last_in_cascade_bit    = reg_wdata[CFG_LAST_CASC];
          s_nxt.last_on_memory_bus_bit = reg_wdata[CFG_LAST_MEM];
        end
        default: begin
          s_nxt.rdata = s_nxt.rdata;  // read-only or unmapped
        end
      endcase
    end

    // idle result pins: default drivers hold their idle values
    s_nxt.local_hit = 1'b0;
    s_nxt.flag      = 1'b0;
    s_nxt.valid     = 1'b0;
    s_nxt.flag_oe   = s_r.last_in_cascade_bit;
    s_nxt.valid_oe  = s_r.last_in_cascade_bit;
    s_nxt.addr_out  = IDLE_ADDR;
    s_nxt.addr_oe   = s_r.last_on_memory_bus_bit;

    unique case (s_r.state)
      ST_IDLE: begin
        if (cmd_valid) begin
          unique case (cmd_code)
            CMD_READ: begin
              if (!cmd_burst) begin
                s_nxt.crdata  = cmd_mask ? mask_mem[cmd_addr]
                                         : data_mem[cmd_addr];
                s_nxt.crvalid = 1'b1;
              end else if (s_r.rptr_len != '0) begin
                // burst with an empty length is ignored
                s_nxt.crdata  = cmd_mask ? mask_mem[s_r.rptr_addr]
                                         : data_mem[s_r.rptr_addr];
                s_nxt.crvalid = 1'b1;
                s_nxt.rptr_addr = s_r.rptr_addr + 15'h0001;
                s_nxt.rptr_len  = s_r.rptr_len - 9'h001;
              end
            end
            CMD_WRITE: begin
              if (!cmd_burst) begin
                we0         = 1'b1;
                s_nxt.page  = '0;
                s_nxt.state = ST_FREE;
              end else if (s_r.wptr_len != '0) begin
                we0         = 1'b1;
                wa0         = s_r.wptr_addr;
                s_nxt.wptr_addr = s_r.wptr_addr + 15'h0001;
                s_nxt.wptr_len  = s_r.wptr_len - 9'h001;
                s_nxt.page  = '0;
                s_nxt.state = ST_FREE;
              end
            end
            CMD_SEARCH: begin
              s_nxt.key   = cmd_key;
              s_nxt.gmask = cmd_gmask;
              s_nxt.found = 1'b0;
              s_nxt.page  = '0;
              s_nxt.state = ST_SEARCH;
            end
            CMD_LEARN: begin
              // learn into the free slot, pair in 136 quadrants
              if (s_r.full != FULL_ON) begin
                we1 = 1'b1;
                we2 = s_r.width_cfg[2*s_r.next_free_index[14:13] +: 2]
                      == W136;
                wd1 = cmd_key[DATA_W-1:0] | 68'h1;
                wd2 = cmd_key[2*DATA_W-1:DATA_W] | 68'h1;
                s_nxt.page  = '0;
                s_nxt.state = ST_FREE;
              end
            end
          endcase
        end
      end
      ST_SEARCH: begin
        // fixed length scan keeps cascaded devices in step
        if (!s_r.found && pg_hit) begin
          s_nxt.found    = 1'b1;
          s_nxt.hit_addr = {s_r.page, pg_off};
        end
        s_nxt.page = s_r.page + 13'h0001;
        if (s_r.page == LAST_PAGE) begin
          s_nxt.local_hit = s_nxt.found;
          s_nxt.state     = ST_ARB;
        end
      end
      ST_FREE: begin
        // lowest empty location; scan stops at first one
        if (pg_free) begin
          s_nxt.next_free_index = {s_r.page, pg_free_off};
          s_nxt.full  = 2'h0;
          s_nxt.state = ST_IDLE;
        end else if (s_r.page == LAST_PAGE) begin
          s_nxt.full  = FULL_ON;
          s_nxt.state = ST_IDLE;
        end else begin
          s_nxt.page = s_r.page + 13'h0001;
        end
      end
      ST_ARB: begin
        // local hit is out now; cascade answers this cycle
        if (s_r.found && !cascade_prior_hit) begin
          s_nxt.addr_out = s_r.hit_addr;
          s_nxt.addr_oe  = 1'b1;
          s_nxt.flag     = 1'b1;
          s_nxt.flag_oe  = 1'b1;
          s_nxt.valid    = 1'b1;
          s_nxt.valid_oe = 1'b1;
        end else if (!s_r.found && !cascade_any_hit) begin
          s_nxt.valid = s_r.last_in_cascade_bit;
        end else begin
          // another device won: release every pin
          s_nxt.addr_oe  = 1'b0;
          s_nxt.flag_oe  = 1'b0;
          s_nxt.valid_oe = 1'b0;
        end
        s_nxt.state = ST_IDLE;
      end
    endcase
    s_nxt.ready = s_nxt.state == ST_IDLE;
  end

  // state register
  always_ff @(posedge clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      s_r                        <= '0;
      s_r.state                  <= ST_IDLE;
      s_r.rptr_addr              <= PTR_ADDR_RESET;
      s_r.rptr_len               <= PTR_LEN_RESET;
      s_r.wptr_addr              <= PTR_ADDR_RESET;
      s_r.wptr_len               <= PTR_LEN_RESET;
      s_r.width_cfg              <= CFG_RESET;
      s_r.next_free_index        <= NF_RESET;
      s_r.ready                  <= 1'b1;
      s_r.addr_out               <= IDLE_ADDR;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the record
  assign reg_rdata              = s_r.rdata;
  assign cmd_ready              = s_r.ready;
  assign cmd_rdata              = s_r.crdata;
  assign cmd_rvalid             = s_r.crvalid;
  assign local_hit_out          = s_r.local_hit;
  assign memory_address_bus     = s_r.addr_out;
  assign memory_address_oe      = s_r.addr_oe;
  assign search_hit_flag        = s_r.flag;
  assign search_hit_flag_oe     = s_r.flag_oe;
  assign search_result_valid    = s_r.valid;
  assign search_result_valid_oe = s_r.valid_oe;
  assign array_full_out         = s_r.full;

endmodule : ternary_search_array_core

/* tsa_core_checker_props.sv */
`timescale 1ns/100ps
// watches the core's ports; only checks, never drives
module tsa_core_checker
  import tsa_pkg::*;
(
  input wire logic              clk,
  input wire logic              nrst,
  input wire logic [REG_AW-1:0] reg_addr,
  input wire logic              reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic              cmd_valid,
  input wire logic [1:0]        cmd_code,
  input wire logic              cmd_ready,
  input wire logic              local_hit_out,
  input wire logic              cascade_prior_hit,
  input wire logic              memory_address_oe,
  input wire logic              search_hit_flag,
  input wire logic              search_hit_flag_oe,
  input wire logic              search_result_valid,
  input wire logic              search_result_valid_oe,
  input wire logic [1:0]        array_full_out
);
  logic [13:0] scnt_r; // cycles since a search was taken

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // search taken on this edge
  sequence s_take_search;
    cmd_valid && cmd_ready && cmd_code == CMD_SEARCH;
  endsequence
  // arbitration pulse with a peer ahead of us
  sequence s_lose_arb;
    local_hit_out && cascade_prior_hit;
  endsequence

  // counts scan, arbitration and result cycles; stops after result
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      scnt_r <= 14'h0000;
    end else if (cmd_valid && cmd_ready && cmd_code == CMD_SEARCH) begin
      scnt_r <= 14'h0001;
    end else if (scnt_r != 14'h0000 && scnt_r < 14'h2002) begin
      scnt_r <= scnt_r + 14'h0001;
    end else begin
      scnt_r <= 14'h0000;
    end
  end

  a_search_busy: assert property (
    s_take_search |=> !cmd_ready [*8])
    else $error("ready rose early in a search");
  a_arb_timing: assert property (
    local_hit_out |-> scnt_r == 14'h2001)
    else $error("local hit outside the arbitration cycle");
  a_pins_after: assert property (
    search_result_valid_oe && search_result_valid |-> scnt_r == 14'h2002)
    else $error("result valid outside the result cycle");
  a_idle_last: assert property (
    search_hit_flag_oe && scnt_r != 14'h2002
    |-> !search_hit_flag && !search_result_valid)
    else $error("idle hit pins not low");
  a_winner_only: assert property (
    s_lose_arb |=> !memory_address_oe && !search_hit_flag_oe &&
    !search_result_valid_oe)
    else $error("losing device drove result pins");
  a_hit_drives: assert property (
    local_hit_out && !cascade_prior_hit
    |=> memory_address_oe && search_hit_flag && search_result_valid)
    else $error("winner did not drive result pins");
  a_nf_reserved: assert property (
    reg_rd && reg_addr == REG_NEXT_FREE |=> reg_rdata[67:15] == 53'h0)
    else $error("next free reserved bits set");
  a_ptr_reserved: assert property (
    reg_rd && (reg_addr == REG_RBURST || reg_addr == REG_WBURST)
    |=> reg_rdata[67:28] == 40'h0 && reg_rdata[18:15] == 4'h0)
    else $error("pointer reserved bits set");
  a_full_code: assert property (
    array_full_out == 2'h0 || array_full_out == FULL_ON)
    else $error("full output has a split code");
endmodule : tsa_core_checker

bind ternary_search_array_core tsa_core_checker u_chk (
  .clk                    (clk),
  .nrst                   (nrst),
  .reg_addr               (reg_addr),
  .reg_rd                 (reg_rd),
  .reg_rdata              (reg_rdata),
  .cmd_valid              (cmd_valid),
  .cmd_code               (cmd_code),
  .cmd_ready              (cmd_ready),
  .local_hit_out          (local_hit_out),
  .cascade_prior_hit      (cascade_prior_hit),
  .memory_address_oe      (memory_address_oe),
  .search_hit_flag        (search_hit_flag),
  .search_hit_flag_oe     (search_hit_flag_oe),
  .search_result_valid    (search_result_valid),
  .search_result_valid_oe (search_result_valid_oe),
  .array_full_out         (array_full_out)
);

/* cascade_peer.sv */
`timescale 1ns/100ps
// stand-in for a higher-priority device on the cascade
module cascade_peer (
  input  wire logic peer_hit,  // bench asks the peer to hold a hit
  output logic      prior_hit, // peer outranks the core
  output logic      any_hit    // some other device hits
);
  // a single peer: its hit is both the prior and the any-hit level,
  // so at most one device can win arbitration
  assign prior_hit = peer_hit;
  assign any_hit   = peer_hit;
endmodule : cascade_peer

/* tb_top.sv */
`timescale 1ns/100ps
module tb_top
  import tsa_pkg::*;
;
  localparam logic [DATA_W-1:0] DAT = 68'h5_a5a5_1234_5678_9abc;
  logic              clk, nrst, reg_wr, reg_rd, peer_hit;
  logic [REG_AW-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata, cmd_wdata, cmd_rdata, got;
  logic              cmd_valid, cmd_burst, cmd_mask, cmd_ready, cmd_rvalid;
  logic [1:0]        cmd_code, full;
  logic [ADDR_W-1:0] cmd_addr, mem_bus;
  logic [KEY_W-1:0]  cmd_key, cmd_gmask;
  logic              prior_hit, any_hit, lhit, addr_oe, hflag, hflag_oe;
  logic              rvalid, rvalid_oe, got_v;
  int                n_fail, total_checks;

  ternary_search_array_core u_dut (
    .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_burst(cmd_burst),
    .cmd_mask(cmd_mask), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .cmd_key(cmd_key), .cmd_gmask(cmd_gmask), .cmd_ready(cmd_ready),
    .cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid),
    .cascade_prior_hit(prior_hit), .cascade_any_hit(any_hit),
    .local_hit_out(lhit), .memory_address_bus(mem_bus),
    .memory_address_oe(addr_oe), .search_hit_flag(hflag),
    .search_hit_flag_oe(hflag_oe), .search_result_valid(rvalid),
    .search_result_valid_oe(rvalid_oe), .array_full_out(full));

  cascade_peer u_peer (.peer_hit(peer_hit), .prior_hit(prior_hit),
    .any_hit(any_hit));

  // free-running 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // counts one comparison, reports a mismatch
  task automatic check(input string nm, input logic [DATA_W-1:0] seen,
                       input logic [DATA_W-1:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : check

  // verdict and end of run
  task automatic stop_test;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test

  // one-cycle write strobe
  task automatic reg_write(input logic [REG_AW-1:0] a,
                           input logic [DATA_W-1:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : reg_write

  // one-cycle read strobe, data stands only in the next cycle
  task automatic reg_read(input logic [REG_AW-1:0] a,
                          input logic [DATA_W-1:0] exp);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    check("reg_rdata", reg_rdata, exp);
  endtask : reg_read

  // one command pulse; waits for ready with a bound
  task automatic do_cmd(input logic [1:0] c, input logic b, input logic m,
                        input logic [DATA_W-1:0] d,
                        input logic [DATA_W-1:0] k,
                        input logic [DATA_W-1:0] g);
    int i;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_code  <= c;
    cmd_burst <= b;
    cmd_mask  <= m;
    cmd_wdata <= d;
    cmd_key   <= KEY_W'(k);
    cmd_gmask <= KEY_W'(g);
    @(posedge clk);
    cmd_valid <= 1'b0;
    #1;
    got   = cmd_rdata;
    got_v = cmd_rvalid;
    // a search holds ready low for the whole scan
    for (i = 0; i < 9000 && cmd_ready !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    if (i == 9000) begin
      n_fail++;
      $display("BAD cmd_ready exp 1 seen 0");
      stop_test();
    end
  endtask : do_cmd

  // main sequence
  initial begin
    nrst = 1'b0;
    {reg_wr, reg_rd, cmd_valid, cmd_burst, cmd_mask, peer_hit} = '0;
    {reg_addr, cmd_code, cmd_addr} = '0;
    {reg_wdata, cmd_wdata, cmd_key, cmd_gmask} = '0;
    n_fail = 0;
    total_checks = 0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    // reset state of the register map
    reg_read(REG_RBURST, '0);
    reg_read(REG_WBURST, '0);
    reg_read(REG_NEXT_FREE, '0);
    // a burst with zero length moves nothing
    do_cmd(CMD_READ, 1'b1, 1'b0, '0, '0, '0);
    check("rvalid", got_v, '0);
    // config, read-only and unmapped places
    reg_write(REG_CONFIG, 68'h300);
    reg_read(REG_CONFIG, 68'h300);
    reg_write(REG_NEXT_FREE, 68'h5);
    reg_read(REG_NEXT_FREE, '0);
    reg_write(7'h70, '1);
    reg_read(7'h70, '0);
    // burst write of entry 0, pointer steps on
    reg_write(REG_WBURST, 68'h200000);
    do_cmd(CMD_WRITE, 1'b1, 1'b0, DAT, '0, '0);
    reg_read(REG_WBURST, 68'h180001);
    // fill the page; both halves of each pair stay empty
    repeat (3) do_cmd(CMD_WRITE, 1'b1, 1'b0, DAT, '0, '0);
    // spent pointer is not restored by the device
    reg_read(REG_WBURST, 68'h4);
    do_cmd(CMD_WRITE, 1'b0, 1'b1, '1, '0, '0);
    // entry 0 has occupancy clear, so it stays the free slot
    reg_read(REG_NEXT_FREE, '0);
    check("full", full, '0);
    // burst read back, pointer steps on
    reg_write(REG_RBURST, 68'h200000);
    do_cmd(CMD_READ, 1'b1, 1'b0, '0, '0, '0);
    check("burst_rd", got, DAT);
    reg_read(REG_RBURST, 68'h180001);
    // run the burst out, then a spent pointer moves nothing
    do_cmd(CMD_READ, 1'b1, 1'b0, '0, '0, '0);
    check("burst_rd2", got, DAT);
    repeat (2) do_cmd(CMD_READ, 1'b1, 1'b0, '0, '0, '0);
    reg_read(REG_RBURST, 68'h4);
    do_cmd(CMD_READ, 1'b1, 1'b0, '0, '0, '0);
    check("rvalid", got_v, '0);
    reg_write(REG_RBURST, 68'h200000);
    do_cmd(CMD_READ, 1'b1, 1'b0, '0, '0, '0);
    check("burst_rd3", got, DAT);
    do_cmd(CMD_READ, 1'b0, 1'b1, '0, '0, '0);
    check("mask_rd", got, '1);
    // flipped key bit hidden by the global mask still hits entry 0
    do_cmd(CMD_SEARCH, 1'b0, 1'b0, '0, DAT ^ 68'h10, ~68'h10);
    check("mem_bus", mem_bus, '0);
    check("hit_flag", hflag, 68'h1);
    check("res_valid", rvalid, 68'h1);
    check("addr_oe", addr_oe, 68'h1);
    // a higher peer hits too, so the core keeps off the pins
    @(posedge clk);
    peer_hit <= 1'b1;
    do_cmd(CMD_SEARCH, 1'b0, 1'b0, '0, DAT, '1);
    check("addr_oe", addr_oe, '0);
    check("flag_oe", hflag_oe, '0);
    check("valid_oe", rvalid_oe, '0);
    // learn into the empty pair of a 136-wide quadrant
    reg_write(REG_CONFIG, 68'h301);
    do_cmd(CMD_LEARN, 1'b0, 1'b0, '0, DAT, '0);
    reg_read(REG_NEXT_FREE, 68'h2);
    do_cmd(CMD_READ, 1'b0, 1'b0, '0, '0, '0);
    check("learned", got, DAT | 68'h1);
    stop_test();
  end
endmodule : tb_top
